// *** hdl/rtc_cmd_pkg.sv ***
//----------------------------------------------------------------------
// Function
// - Control 0000 loads the pointer; 0011 adjust, 0100/0101 date-skip clear/set, 0110 compare clear.
// - One command exposes flags for reading; another clears prescaler and seconds, no carry.
// - Time adjust clears seconds and carries into minutes when seconds are 30 or more.
// - Time adjust carries only when seconds are 30 or more.
// - Pointer bit 2 picks time or alarm; bits 1:0 pick hours, minutes, days, months.
// - Pointer bits 1:0 step after each data byte only under pointer-load.
// - Stepping past months wraps to hours; bit 2 never changes.
// - Written bytes: lower digit bits 3..0, upper digit masked per field.
// - Read bytes use the same layout with unused upper bits as zero.
// - Flag byte: zeros, minute, seconds, date-skip, compare-match, power-fail.
// - Latched control nibble holds until a new command-pointer byte arrives.
// - Matching address acked; 0000 with bit 3 low acks all, bit 3 high none.
// - Controls 0001..0110 ack command only; 0111 or bit 7 set ack nothing.
// - Reading straight after address serves retained pointer and command.
// - Command-pointer byte follows the address; pointer used only under pointer-load.
// - Two address bits compare against the two select pins.
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

package rtc_cmd_pkg;

  //--------------------------------------------------------------------
  // Commands and constants
  //--------------------------------------------------------------------
  localparam logic [3:0] CTRL_POINTER_LOAD   = 4'h0;
  localparam logic [3:0] CTRL_FLAG_READ      = 4'h1;
  localparam logic [3:0] CTRL_PRESCALER_RST  = 4'h2;
  localparam logic [3:0] CTRL_TIME_ADJUST    = 4'h3;
  localparam logic [3:0] CTRL_DATE_SKIP_CLR  = 4'h4;
  localparam logic [3:0] CTRL_DATE_SKIP_SET  = 4'h5;
  localparam logic [3:0] CTRL_COMPARE_CLR    = 4'h6;
  localparam logic [3:0] SECONDS_CARRY_TENS  = 4'h3;
  localparam logic [3:0] BIT_CNT_BYTE        = 4'h8;
  localparam logic [3:0] BIT_CNT_ACK         = 4'h9;
  localparam logic [1:0] FIELD_HOURS         = 2'h0;
  localparam logic [1:0] FIELD_MINUTES       = 2'h1;
  localparam logic [1:0] FIELD_DAYS          = 2'h2;
  localparam logic [1:0] FIELD_MONTHS        = 2'h3;
  localparam logic [4:0] ADDR_FIXED_DEFAULT  = 5'h14;
  localparam logic [3:0] CTRL_RESET          = 4'h0;
  localparam logic [2:0] POINTER_RESET       = 3'h0;
  localparam logic [1:0] SYNC_RESET          = 2'h3;

  //--------------------------------------------------------------------
  // Carriers
  //--------------------------------------------------------------------
  typedef logic [7:0][7:0] regs_t;

  typedef struct packed {
    logic       minute_ind;
    logic       seconds_ind;
    logic       date_skip_flag;
    logic       compare_flag;
    logic       power_fail_flag;
  } status_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] sel;
    logic [3:0] upper;
    logic [3:0] lower;
  } wr_s;

  typedef struct packed {
    logic       seconds_clear;
    logic       minute_carry;
    logic       prescaler_clear;
    logic       date_skip_set;
    logic       date_skip_clear;
    logic       compare_clear;
  } cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_CMD    = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_IGNORE = 3'b101
  } state_e;

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  function automatic logic [3:0] upper_mask(input logic [1:0] field);
    unique case (field)
      FIELD_HOURS:   upper_mask = 4'h3;
      FIELD_MINUTES: upper_mask = 4'h7;
      FIELD_DAYS:    upper_mask = 4'h3;
      FIELD_MONTHS:  upper_mask = 4'h1;
    endcase
  endfunction : upper_mask

  function automatic logic [1:0] sync_init(input logic dummy);
    sync_init = SYNC_RESET;
  endfunction : sync_init

endpackage : rtc_cmd_pkg

// Two-stage synchroniser for pin inputs; first stage feeds only the second
module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1_q     <= '1;
      pin_sync_out <= '1;
    end else begin
      stage1_q     <= pin_in;
      pin_sync_out <= stage1_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// *** hdl/rtc_pointer_command_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none

module rtc_pointer_command_decoder #(
  parameter logic [4:0] ADDR_FIXED = rtc_cmd_pkg::ADDR_FIXED_DEFAULT
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Serial bus pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Hardware select pins
  input  wire logic                 hw_select_pin_0,
  input  wire logic                 hw_select_pin_1,
  // Counter side, read
  input  wire logic [7:0]           seconds_bcd,
  input  wire rtc_cmd_pkg::status_s status_in,
  input  wire rtc_cmd_pkg::regs_t   reg_rd,
  // Counter side, write and commands
  output rtc_cmd_pkg::wr_s          wr_out,
  output rtc_cmd_pkg::cmd_s         cmd_out
);

  //--------------------------------------------------------------------
  // Pin synchronisation and bus events
  //--------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       sel0_s;
  logic       sel1_s;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk     (core_clk),
    .reset        (reset),
    .pin_in       ({scl_in, sda_in, hw_select_pin_1, hw_select_pin_0}),
    .pin_sync_out (pins_s)
  );

  assign scl_s  = pins_s[3];
  assign sda_s  = pins_s[2];
  assign sel1_s = pins_s[1];
  assign sel0_s = pins_s[0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  //--------------------------------------------------------------------
  // Bit counter and receive shifter
  //--------------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic       byte_done;
  logic       ack_end;

  assign byte_done = scl_fall && (cnt_q == rtc_cmd_pkg::BIT_CNT_BYTE);
  assign ack_end   = scl_fall && (cnt_q == rtc_cmd_pkg::BIT_CNT_ACK);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      rx_q  <= 8'h00;
    end else if (start_det || stop_det) begin
      cnt_q <= 4'h0;
    end else if (scl_rise && cnt_q < rtc_cmd_pkg::BIT_CNT_ACK) begin
      if (cnt_q < rtc_cmd_pkg::BIT_CNT_BYTE) begin
        rx_q <= {rx_q[6:0], sda_s};
      end
      cnt_q <= cnt_q + 4'h1;
    end else if (ack_end) begin
      cnt_q <= 4'h0;
    end
  end

  //--------------------------------------------------------------------
  // Decode of the received byte
  //--------------------------------------------------------------------
  rtc_cmd_pkg::state_e state_q;
  logic [3:0]          ctrl_q;
  logic [2:0]          ptr_q;
  logic                data_ack_q;
  logic                master_ack_q;
  logic                addr_match;
  logic                ptr_load_ok;
  logic                cmd_ok;
  logic                ack_d;
  logic [2:0]          ptr_next;

  assign addr_match  = (rx_q[7:1] == {ADDR_FIXED, sel1_s, sel0_s});
  assign ptr_load_ok = (rx_q[7:3] == 5'h00);
  assign cmd_ok      = (rx_q[7:4] >= rtc_cmd_pkg::CTRL_FLAG_READ) &&
                       (rx_q[7:4] <= rtc_cmd_pkg::CTRL_COMPARE_CLR);
  assign ptr_next    = {ptr_q[2], ptr_q[1:0] + 2'h1};

  always_comb begin
    unique case (state_q)
      rtc_cmd_pkg::ST_ADDR:  ack_d = addr_match;
      rtc_cmd_pkg::ST_CMD:   ack_d = ptr_load_ok || cmd_ok;
      rtc_cmd_pkg::ST_WDATA: ack_d = data_ack_q;
      default:               ack_d = 1'b0;
    endcase
  end

  //--------------------------------------------------------------------
  // Transfer state, pointer and latched control
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= rtc_cmd_pkg::ST_IDLE;
    end else if (start_det) begin
      state_q <= rtc_cmd_pkg::ST_ADDR;
    end else if (stop_det) begin
      state_q <= rtc_cmd_pkg::ST_IDLE;
    end else if (byte_done) begin
      unique case (state_q)
        rtc_cmd_pkg::ST_ADDR: begin
          if (!addr_match) begin
            state_q <= rtc_cmd_pkg::ST_IGNORE;
          end else if (rx_q[0]) begin
            state_q <= rtc_cmd_pkg::ST_RDATA;
          end else begin
            state_q <= rtc_cmd_pkg::ST_CMD;
          end
        end
        rtc_cmd_pkg::ST_CMD:   state_q <= rtc_cmd_pkg::ST_WDATA;
        rtc_cmd_pkg::ST_RDATA: state_q <= rtc_cmd_pkg::ST_RDATA;
        rtc_cmd_pkg::ST_WDATA: state_q <= rtc_cmd_pkg::ST_WDATA;
        rtc_cmd_pkg::ST_IDLE:  state_q <= rtc_cmd_pkg::ST_IDLE;
        rtc_cmd_pkg::ST_IGNORE: state_q <= rtc_cmd_pkg::ST_IGNORE;
        default:               state_q <= rtc_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Control and pointer survive across transfers; only a new command byte moves ctrl
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q     <= rtc_cmd_pkg::CTRL_RESET;
      ptr_q      <= rtc_cmd_pkg::POINTER_RESET;
      data_ack_q <= 1'b0;
    end else if (byte_done) begin
      if (state_q == rtc_cmd_pkg::ST_CMD) begin
        ctrl_q     <= rx_q[7:4];
        data_ack_q <= ptr_load_ok;
        if (ptr_load_ok) begin
          ptr_q <= rx_q[2:0];
        end
      end else if (state_q == rtc_cmd_pkg::ST_WDATA && data_ack_q) begin
        ptr_q <= ptr_next;
      end else if (state_q == rtc_cmd_pkg::ST_RDATA &&
                   ctrl_q == rtc_cmd_pkg::CTRL_POINTER_LOAD) begin
        ptr_q <= ptr_next;
      end
    end
  end

  // Master ack on the ninth clock of a read byte decides whether we go on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      master_ack_q <= 1'b0;
    end else if (byte_done && state_q == rtc_cmd_pkg::ST_ADDR) begin
      master_ack_q <= 1'b1;
    end else if (scl_rise && cnt_q == rtc_cmd_pkg::BIT_CNT_BYTE &&
                 state_q == rtc_cmd_pkg::ST_RDATA) begin
      master_ack_q <= ~sda_s;
    end
  end

  //--------------------------------------------------------------------
  // Command pulses toward the counters
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_out <= '0;
    end else begin
      cmd_out <= '0;
      if (byte_done && state_q == rtc_cmd_pkg::ST_CMD) begin
        unique case (rx_q[7:4])
          rtc_cmd_pkg::CTRL_PRESCALER_RST: begin
            cmd_out.prescaler_clear <= 1'b1;
            cmd_out.seconds_clear   <= 1'b1;
          end
          rtc_cmd_pkg::CTRL_TIME_ADJUST: begin
            cmd_out.seconds_clear <= 1'b1;
            cmd_out.minute_carry  <= seconds_bcd[7:4] >= rtc_cmd_pkg::SECONDS_CARRY_TENS;
          end
          rtc_cmd_pkg::CTRL_DATE_SKIP_CLR: cmd_out.date_skip_clear <= 1'b1;
          rtc_cmd_pkg::CTRL_DATE_SKIP_SET: cmd_out.date_skip_set   <= 1'b1;
          rtc_cmd_pkg::CTRL_COMPARE_CLR:   cmd_out.compare_clear   <= 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Write port toward the counters
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_out <= '0;
    end else begin
      wr_out.valid <= 1'b0;
      if (byte_done && state_q == rtc_cmd_pkg::ST_WDATA && data_ack_q) begin
        wr_out.valid <= 1'b1;
        wr_out.sel   <= ptr_q;
        wr_out.lower <= rx_q[3:0];
        wr_out.upper <= rx_q[7:4] & rtc_cmd_pkg::upper_mask(ptr_q[1:0]);
      end
    end
  end

  //--------------------------------------------------------------------
  // Read byte and serial data out
  //--------------------------------------------------------------------
  logic [7:0] tx_byte;
  logic [7:0] sel_byte;
  logic [7:0] tx_q;
  logic       tx_act_q;

  assign sel_byte = reg_rd[ptr_q];

  always_comb begin
    if (ctrl_q == rtc_cmd_pkg::CTRL_FLAG_READ) begin
      tx_byte = {3'h0, status_in};
    end else begin
      tx_byte = {sel_byte[7:4] & rtc_cmd_pkg::upper_mask(ptr_q[1:0]), sel_byte[3:0]};
    end
  end

  // Only ever pulls low; a released line reads high through the pull-up
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
      tx_q     <= 8'h00;
      tx_act_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe   <= 1'b0;
      tx_act_q <= 1'b0;
    end else if (byte_done) begin
      sda_oe   <= ack_d;
      tx_act_q <= 1'b0;
    end else if (ack_end) begin
      if (state_q == rtc_cmd_pkg::ST_RDATA && master_ack_q) begin
        tx_q     <= tx_byte;
        sda_oe   <= ~tx_byte[7];
        tx_act_q <= 1'b1;
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (scl_fall && tx_act_q) begin
      tx_q   <= {tx_q[6:0], 1'b0};
      sda_oe <= ~tx_q[6];
    end
  end

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  wire cmd_byte_done = byte_done && (state_q == rtc_cmd_pkg::ST_CMD);
  wire tx_load       = ack_end && (state_q == rtc_cmd_pkg::ST_RDATA) && master_ack_q;

  addr_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    byte_done && state_q == rtc_cmd_pkg::ST_ADDR && addr_match |=> sda_oe)
    else $error("address match not acknowledged");

  ptr_load_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_byte_done && rx_q[7:4] == 4'h0 |=> sda_oe == !$past(rx_q[3]) && data_ack_q == !$past(rx_q[3]))
    else $error("pointer-load acknowledge wrong");

  cmd_nack_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_byte_done && (rx_q[7:4] == 4'h7 || rx_q[7]) |=> !sda_oe && !data_ack_q && $stable(ptr_q))
    else $error("invalid command acknowledged or acted on");

  adjust_carry_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_byte_done && rx_q[7:4] == 4'h3 |=> cmd_out.seconds_clear &&
      cmd_out.minute_carry == ($past(seconds_bcd[7:4]) >= 4'h3))
    else $error("time adjust carry wrong");

  prescaler_rst_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_byte_done && rx_q[7:4] == 4'h2 |=> cmd_out.prescaler_clear && cmd_out.seconds_clear &&
      !cmd_out.minute_carry ##1 cmd_out == '0)
    else $error("prescaler reset pulse wrong");

  ptr_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_out.valid |-> ptr_q == {wr_out.sel[2], wr_out.sel[1:0] + 2'h1})
    else $error("pointer step or wrap wrong");

  ptr_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    byte_done && state_q == rtc_cmd_pkg::ST_RDATA && ctrl_q != 4'h0 |=> ptr_q == $past(ptr_q))
    else $error("pointer stepped outside pointer-load");

  ctrl_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !cmd_byte_done |=> ctrl_q == $past(ctrl_q))
    else $error("control nibble changed without command byte");

  write_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_out.valid && wr_out.sel[1:0] == 2'h3 |-> wr_out.upper[3:1] == 3'h0)
    else $error("month upper digit not masked");

  flag_read_a: assert property (@(posedge core_clk) disable iff (reset)
    tx_load && ctrl_q == 4'h1 |=> tx_q == {3'h0, $past(status_in)})
    else $error("flag byte layout wrong");

  read_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    tx_load && ctrl_q != 4'h1 && ptr_q[1:0] != 2'h1 |=> tx_q[7:6] == 2'h0)
    else $error("read upper bits not zero");

  data_nack_a: assert property (@(posedge core_clk) disable iff (reset)
    byte_done && state_q == rtc_cmd_pkg::ST_WDATA && !data_ack_q |=> !sda_oe && !wr_out.valid)
    else $error("refused data byte acknowledged or written");

  skip_set_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_byte_done && rx_q[7:4] == 4'h5 |=> cmd_out.date_skip_set && !cmd_out.date_skip_clear)
    else $error("date-skip set pulse wrong");

endmodule : rtc_pointer_command_decoder

`default_nettype wire

// *** verification/i2c_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Bus master model: open-drain SDA with pull-up, SCL still outside frames
// ----------------------------------------------------------------
module i2c_master_model (
  // Pacing clock
  input  wire logic core_clk,
  // Device side of the wire
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_m;

  // Released wire floats to the pull-up level
  assign sda = sda_m & ~sda_oe;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w

  // SDA moves two clocks into the low phase, sampled two clocks into the high phase
  task automatic bit_cycle(input logic b, output logic r);
    scl = 1'b0;
    w(2);
    sda_m = b;
    w(2);
    scl = 1'b1;
    w(2);
    r = sda;
    w(2);
  endtask : bit_cycle

  task automatic start;
    w(4);
    sda_m = 1'b0;
    w(4);
  endtask : start

  task automatic stop;
    scl = 1'b0;
    w(2);
    sda_m = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_m = 1'b1;
    w(4);
  endtask : stop

  // Caller sends address, then command-pointer byte, then data
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
    bit_cycle(1'b1, ack);
  endtask : wr_byte

  // Read may follow the address byte directly
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(last, r);
  endtask : rd_byte
endmodule : i2c_master_model

`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] sec;
    logic       ack_c;
    logic       ack_d;
    logic [5:0] pulses;
  } row_s;

  // Select pins 1/0 = 0/1, so address byte is {5'h14, 0, 1, rw}
  localparam logic [7:0]  ADDR_W   = 8'hA2;
  localparam logic [7:0]  ADDR_R   = 8'hA3;
  localparam logic [10:0] EXP_W[4] = '{11'h63F, 11'h71F, 11'h43F, 11'h57F};
  localparam logic [7:0]  EXP_R[4] = '{8'h36, 8'h17, 8'h34, 8'h75};

  logic                 core_clk, reset, scl, sda, sda_out, sda_oe, pin0, pin1, clr, a;
  logic [7:0]           seconds_bcd, d;
  rtc_cmd_pkg::status_s status_in;
  rtc_cmd_pkg::regs_t   reg_rd;
  rtc_cmd_pkg::wr_s     wr_out, wr_last;
  rtc_cmd_pkg::cmd_s    cmd_out, cmd_seen;
  int                   n_mismatch, tests_run, n_wr, k;
  row_s                 rows[11];

  rtc_pointer_command_decoder dut (
    .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_select_pin_0(pin0), .hw_select_pin_1(pin1), .seconds_bcd(seconds_bcd),
    .status_in(status_in), .reg_rd(reg_rd), .wr_out(wr_out), .cmd_out(cmd_out));

  i2c_master_model m (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Pulse capture: outputs stand one cycle only
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (clr) cmd_seen <= '0;
    else cmd_seen <= cmd_seen | cmd_out;
    if (wr_out.valid) begin
      wr_last <= wr_out;
      n_wr    <= n_wr + 1;
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk    = 1'b0;
    reset       = 1'b1;
    pin0        = 1'b1;
    pin1        = 1'b0;
    clr         = 1'b0;
    seconds_bcd = 8'h00;
    status_in   = '0;
    reg_rd      = 64'hF7F6F5F4F3F2F1F0;
    // Command byte, seconds, ack levels (0 = pulled low), expected pulses
    rows = '{{8'h00, 8'h00, 1'b0, 1'b0, 6'h00}, {8'h08, 8'h00, 1'b1, 1'b1, 6'h00},
             {8'h10, 8'h00, 1'b0, 1'b1, 6'h00}, {8'h20, 8'h00, 1'b0, 1'b1, 6'h28},
             {8'h30, 8'h29, 1'b0, 1'b1, 6'h20}, {8'h30, 8'h30, 1'b0, 1'b1, 6'h30},
             {8'h40, 8'h00, 1'b0, 1'b1, 6'h02}, {8'h50, 8'h00, 1'b0, 1'b1, 6'h04},
             {8'h60, 8'h00, 1'b0, 1'b1, 6'h01}, {8'h70, 8'h00, 1'b1, 1'b1, 6'h00},
             {8'h80, 8'h00, 1'b1, 1'b1, 6'h00}};
    repeat (3) @(negedge core_clk);
    check({sda_out, sda_oe, wr_out, cmd_out}, 24'h0);
    reset = 1'b0;
    foreach (rows[i]) begin
      seconds_bcd = rows[i].sec;
      clr = 1'b1;
      @(negedge core_clk);
      clr = 1'b0;
      k = n_wr;
      m.start();
      m.wr_byte(ADDR_W, a);
      check(a, 1'b0);
      m.wr_byte(rows[i].cmd, a);
      check(a, rows[i].ack_c);
      m.wr_byte(8'hFF, a);
      check(a, rows[i].ack_d);
      m.stop();
      check(cmd_seen, rows[i].pulses);
      check(24'(n_wr - k), {23'h0, ~rows[i].ack_d});
    end
    check({wr_last.sel, wr_last.upper, wr_last.lower}, 11'h03F);
    // Foreign address must be ignored
    m.start();
    m.wr_byte(8'hA0, a);
    check(a, 1'b1);
    m.stop();
    // Four writes from alarm days: wrap stays in the alarm group
    m.start();
    m.wr_byte(ADDR_W, a);
    m.wr_byte(8'h06, a);
    for (int i = 0; i < 4; i++) begin
      m.wr_byte(8'hFF, a);
      check({wr_last.sel, wr_last.upper, wr_last.lower}, EXP_W[i]);
    end
    m.stop();
    // Read straight after the address, from the retained pointer
    m.start();
    m.wr_byte(ADDR_R, a);
    check(a, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m.rd_byte(i == 3, d);
      check(d, EXP_R[i]);
    end
    m.stop();
    // Flag read command is retained over two separate reads
    m.start();
    m.wr_byte(ADDR_W, a);
    m.wr_byte(8'h10, a);
    m.stop();
    for (int i = 0; i < 2; i++) begin
      status_in = (i == 0) ? 5'h15 : 5'h0A;
      m.start();
      m.wr_byte(ADDR_R, a);
      m.rd_byte(1'b1, d);
      m.stop();
      check(d, (i == 0) ? 8'h15 : 8'h0A);
    end
    // Reset in mid-run brings back pointer-load at time hours
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    check({sda_out, sda_oe, wr_out, cmd_out}, 24'h0);
    reset = 1'b0;
    m.start();
    m.wr_byte(ADDR_R, a);
    check(a, 1'b0);
    m.rd_byte(1'b1, d);
    m.stop();
    check(d, 8'h30);
    // Moving the select pins moves the address
    pin0 = 1'b0;
    pin1 = 1'b1;
    m.start();
    m.wr_byte(ADDR_W, a);
    check(a, 1'b1);
    m.stop();
    m.start();
    m.wr_byte(8'hA4, a);
    check(a, 1'b0);
    m.stop();
    conclude();
  end

  // Whole run is near 4400 clocks; a hang is cut well beyond that
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench

`default_nettype wire
